// *** src/ldm_pkg.sv ***
package ldm_pkg;

  // Register addresses on the serial control bus.
  localparam logic [7:0] LDM_MODE_ADDR = 8'h01;
  localparam logic [7:0] LDM_FLAG_ADDR = 8'h02;
  localparam logic [7:0] LDM_BLMAX_ADDR = 8'h13;

  // Mode control field positions.
  localparam int LDM_MODE_RETRIG_BIT = 6;
  localparam int LDM_MODE_RUN_BIT = 5;
  localparam int LDM_MODE_GRST_BIT = 4;
  localparam int LDM_MODE_GHOLD_BIT = 3;
  localparam int LDM_MODE_INDEP_BIT = 2;
  localparam int LDM_MODE_BL_BIT = 0;

  // Event flag field positions.
  localparam int LDM_FLAG_INDEP_BIT = 6;
  localparam int LDM_FLAG_BLOFF_BIT = 5;
  localparam int LDM_FLAG_SHORT_BIT = 4;
  localparam int LDM_FLAG_THERM_BIT = 3;
  localparam int LDM_FLAG_OVP_BIT = 2;

  // Implemented bits; everything else is reserved and reads as zero.
  localparam logic [7:0] LDM_MODE_MASK = 8'h7D;
  localparam logic [7:0] LDM_FLAG_MASK = 8'h7C;
  localparam logic [7:0] LDM_MODE_RESET = 8'h00;
  localparam logic [7:0] LDM_FLAG_RESET = 8'h00;
  localparam logic [7:0] LDM_RDATA_RESET = 8'h00;

  // Interrupt release time after a clear attempt.
  localparam int LDM_CLK_KHZ = 40000;
  localparam int LDM_RETRIG_TIME_US = 50;
  localparam int LDM_RETRIG_CYCLES = (LDM_RETRIG_TIME_US * LDM_CLK_KHZ + 999) / 1000;
  localparam int LDM_CNT_W = 12;

  // Decoded register access from the serial front end.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ldm_acc_t;

  // Asynchronous analog fault detectors.
  typedef struct packed {
    logic short_det;
    logic therm_det;
    logic ovp_det;
  } ldm_fault_t;

  typedef enum logic [0:0] {
    LDM_IRQ_IDLE = 1'b0,
    LDM_IRQ_HOLD = 1'b1
  } ldm_irq_state_t;

endpackage : ldm_pkg

// *** src/ldm_mode_irq.sv ***
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// RQ1: Retrigger mode set: release interrupt 50 us after clear, then reassert if pending.
// RQ2: Retrigger mode clear: interrupt stays asserted when cleared while events pending.
// RQ3: Run bit 5 one means normal operation; zero means standby, bus only.
// RQ4: Gain-reset option forces pump gain 1x on each backlight max register write.
// RQ5: Gain-hold set: gain may rise but never falls until all LEDs off.
// RQ6: Gain-hold clear: gain steps freely up and down.
// RQ7: Independent master enable bit 2 switches the independent sink group on or off.
// RQ8: Independent master enable ignored while any group automatic enable is set.
// RQ9: Backlight master enable bit 0 switches the backlight sink group on or off.
// RQ10: Flag bit 6 sets once all selected independent sinks ramped off.
// RQ11: Flag bit 5 sets when backlight group fade to off finishes.
// RQ12: Flag bit 4 sets on short or overload of pump output or sinks.
// RQ13: Flag bit 3 sets on thermal shutdown.
// RQ14: Flag bit 2 sets when pump output exceeds the overvoltage threshold.
// RQ15: Writing one clears a flag; zeros and reads leave flags alone.
// RQ16: Only enabled flags drive the interrupt; disabled flags still latch.
// RQ17: Backlight-off flag sets after fade-out and after a dimming profile.
// RQ18: Reserved bits of both registers read zero and ignore writes.
module ldm_mode_irq
  import ldm_pkg::*;
#(
  parameter int NUM_SINKS = 9
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Register access from the serial front end
  input wire ldm_acc_t acc_i,
  output logic [7:0] rdata_o,
  // Interrupt enables and sink status from neighbouring logic
  input wire logic [7:0] int_enable_i,
  input wire logic [NUM_SINKS-1:0] indep_group_i,
  input wire logic [NUM_SINKS-1:0] sink_auto_enable_i,
  input wire logic [NUM_SINKS-1:0] indep_off_sel_i,
  input wire logic [NUM_SINKS-1:0] sink_lit_i,
  input wire logic all_leds_off_i,
  // Fade engine events, one-cycle pulses
  input wire logic bl_fade_done_i,
  input wire logic bl_profile_done_i,
  // Analog fault detectors, asynchronous levels
  input wire ldm_fault_t fault_i,
  // Control outputs
  output logic run_o,
  output logic backlight_sinks_on_o,
  output logic indep_sinks_on_o,
  output logic gain_force_1x_o,
  output logic gain_down_ok_o,
  // Host interrupt line, active low
  output logic irq_b_o
);

  // The sink vectors are refused at elaboration beyond sixteen entries.
  if (NUM_SINKS < 1 || NUM_SINKS > 16) begin : g_bad_sinks
    $error("NUM_SINKS out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register bank

  logic [7:0] mode_control_reg;
  logic [7:0] mode_control_next;
  logic [7:0] event_flags_reg;
  logic [7:0] event_flags_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic wr_mode;
  logic wr_flag;
  logic wr_blmax;

  ldm_fault_t flt_s1_reg;
  ldm_fault_t flt_s2_reg;
  ldm_fault_t flt_d_reg;
  ldm_fault_t flt_rise;
  logic sel_lit_reg;
  logic sel_lit;

  always_comb begin
    wr_mode = acc_i.wr && (acc_i.addr == LDM_MODE_ADDR);
    wr_flag = acc_i.wr && (acc_i.addr == LDM_FLAG_ADDR);
    wr_blmax = acc_i.wr && (acc_i.addr == LDM_BLMAX_ADDR);
    flt_rise = flt_s2_reg & ~flt_d_reg;
    sel_lit = |(indep_off_sel_i & sink_lit_i);
    flag_set = 8'h00;
    // A selected group that was lit and is now fully dark reports once.
    flag_set[LDM_FLAG_INDEP_BIT] = sel_lit_reg && !sel_lit && (|indep_off_sel_i); // [RQ10]
    flag_set[LDM_FLAG_BLOFF_BIT] = bl_fade_done_i || bl_profile_done_i; // [RQ11] [RQ17]
    flag_set[LDM_FLAG_SHORT_BIT] = flt_rise.short_det; // [RQ12]
    flag_set[LDM_FLAG_THERM_BIT] = flt_rise.therm_det; // [RQ13]
    flag_set[LDM_FLAG_OVP_BIT] = flt_rise.ovp_det; // [RQ14]
    flag_clr = wr_flag ? acc_i.wdata : 8'h00;
    // A new event in the clearing cycle survives the clear.
    event_flags_next = ((event_flags_reg & ~flag_clr) | flag_set) & LDM_FLAG_MASK; // [RQ15] [RQ18]
    mode_control_next = wr_mode ? (acc_i.wdata & LDM_MODE_MASK) : mode_control_reg; // [RQ18]
    rdata_next = rdata_reg;
    if (acc_i.rd) begin
      case (acc_i.addr)
        LDM_MODE_ADDR: rdata_next = mode_control_reg;
        LDM_FLAG_ADDR: rdata_next = event_flags_reg; // [RQ15]
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      mode_control_reg <= LDM_MODE_RESET;
      event_flags_reg <= LDM_FLAG_RESET;
      rdata_reg <= LDM_RDATA_RESET;
      flt_s1_reg <= '0;
      flt_s2_reg <= '0;
      flt_d_reg <= '0;
      sel_lit_reg <= 1'b0;
    end else begin
      mode_control_reg <= mode_control_next;
      event_flags_reg <= event_flags_next;
      rdata_reg <= rdata_next;
      flt_s1_reg <= fault_i;
      flt_s2_reg <= flt_s1_reg;
      flt_d_reg <= flt_s2_reg;
      sel_lit_reg <= sel_lit;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sink enables and charge-pump gain policy

  logic run_reg;
  logic run_next;
  logic bl_on_reg;
  logic bl_on_next;
  logic indep_on_reg;
  logic indep_on_next;
  logic gain_force_reg;
  logic gain_force_next;
  logic gain_down_reg;
  logic gain_down_next;
  logic indep_override;

  always_comb begin
    indep_override = |(sink_auto_enable_i & indep_group_i);
    run_next = mode_control_reg[LDM_MODE_RUN_BIT]; // [RQ3]
    // Standby keeps only the bus alive, so both groups are forced dark.
    bl_on_next = mode_control_reg[LDM_MODE_BL_BIT] && run_next; // [RQ9] [RQ3]
    // An automatic enable freezes the group, yet standby still darkens it.
    indep_on_next = run_next && (indep_override ? indep_on_reg : // [RQ8] [RQ3]
                    mode_control_reg[LDM_MODE_INDEP_BIT]); // [RQ7]
    gain_force_next = wr_blmax && mode_control_reg[LDM_MODE_GRST_BIT]; // [RQ4]
    // Raising gain is always permitted; only stepping down is gated.
    gain_down_next = !mode_control_reg[LDM_MODE_GHOLD_BIT] || all_leds_off_i; // [RQ5] [RQ6]
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      run_reg <= 1'b0;
      bl_on_reg <= 1'b0;
      indep_on_reg <= 1'b0;
      gain_force_reg <= 1'b0;
      gain_down_reg <= 1'b1;
    end else begin
      run_reg <= run_next;
      bl_on_reg <= bl_on_next;
      indep_on_reg <= indep_on_next;
      gain_force_reg <= gain_force_next;
      gain_down_reg <= gain_down_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Host interrupt line

  ldm_irq_state_t irq_state_reg;
  ldm_irq_state_t irq_state_next;
  logic [LDM_CNT_W-1:0] hold_cnt_reg;
  logic [LDM_CNT_W-1:0] hold_cnt_next;
  logic irq_b_reg;
  logic irq_b_next;
  logic clear_attempt;
  logic pend_next;

  always_comb begin
    clear_attempt = wr_flag && (|(acc_i.wdata & LDM_FLAG_MASK));
    pend_next = |(event_flags_next & int_enable_i & LDM_FLAG_MASK); // [RQ16]
    irq_state_next = irq_state_reg;
    hold_cnt_next = hold_cnt_reg;
    irq_b_next = !pend_next; // [RQ2] [RQ16]
    case (irq_state_reg)
      LDM_IRQ_IDLE: begin
        if (clear_attempt && mode_control_reg[LDM_MODE_RETRIG_BIT]) begin
          irq_state_next = LDM_IRQ_HOLD; // [RQ1]
          hold_cnt_next = LDM_CNT_W'(LDM_RETRIG_CYCLES - 1);
          irq_b_next = 1'b1;
        end
      end
      LDM_IRQ_HOLD: begin
        // A further clear during the release restarts the full release time.
        if (clear_attempt) begin
          hold_cnt_next = LDM_CNT_W'(LDM_RETRIG_CYCLES - 1);
          irq_b_next = 1'b1;
        end else if (hold_cnt_reg == '0) begin
          irq_state_next = LDM_IRQ_IDLE; // [RQ1]
        end else begin
          hold_cnt_next = hold_cnt_reg - 1'b1;
          irq_b_next = 1'b1;
        end
      end
      default: begin
        irq_state_next = LDM_IRQ_IDLE;
        irq_b_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      irq_state_reg <= LDM_IRQ_IDLE;
      hold_cnt_reg <= '0;
      irq_b_reg <= 1'b1;
    end else begin
      irq_state_reg <= irq_state_next;
      hold_cnt_reg <= hold_cnt_next;
      irq_b_reg <= irq_b_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign run_o = run_reg;
  assign backlight_sinks_on_o = bl_on_reg;
  assign indep_sinks_on_o = indep_on_reg;
  assign gain_force_1x_o = gain_force_reg;
  assign gain_down_ok_o = gain_down_reg;
  assign irq_b_o = irq_b_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  release_start_a: assert property ( // [RQ1]
    (irq_state_reg == LDM_IRQ_IDLE && clear_attempt && mode_control_reg[LDM_MODE_RETRIG_BIT])
    |=> irq_b_o [*8] ##0 (irq_state_reg == LDM_IRQ_HOLD))
    else $error("interrupt not released after clear attempt");
  release_end_a: assert property ( // [RQ1]
    (irq_state_reg == LDM_IRQ_HOLD && hold_cnt_reg == '0 && !clear_attempt && pend_next)
    |=> !irq_b_o && irq_state_reg == LDM_IRQ_IDLE)
    else $error("pending event not reasserted after release");
  steady_irq_a: assert property ( // [RQ2]
    (irq_state_reg == LDM_IRQ_IDLE && !mode_control_reg[LDM_MODE_RETRIG_BIT] && pend_next)
    |=> !irq_b_o)
    else $error("interrupt dropped while event pending");
  standby_dark_a: assert property ( // [RQ3]
    !run_o |-> !backlight_sinks_on_o && !indep_sinks_on_o)
    else $error("sinks on in standby");
  gain_reset_a: assert property ( // [RQ4]
    wr_blmax |=> gain_force_1x_o == $past(mode_control_reg[LDM_MODE_GRST_BIT]))
    else $error("gain force mismatch on max current write");
  gain_hold_a: assert property ( // [RQ5]
    (mode_control_reg[LDM_MODE_GHOLD_BIT] && !all_leds_off_i) |=> !gain_down_ok_o)
    else $error("gain allowed down under hold");
  gain_free_a: assert property ( // [RQ6]
    !mode_control_reg[LDM_MODE_GHOLD_BIT] |=> gain_down_ok_o)
    else $error("gain down blocked without hold");
  indep_master_a: assert property ( // [RQ7]
    !indep_override |=> indep_sinks_on_o == $past(mode_control_reg[LDM_MODE_INDEP_BIT]
                                                  && mode_control_reg[LDM_MODE_RUN_BIT]))
    else $error("independent group not following master enable");
  indep_override_a: assert property ( // [RQ8]
    (indep_override && mode_control_reg[LDM_MODE_RUN_BIT]) |=> $stable(indep_sinks_on_o))
    else $error("master enable acted under automatic enable");
  backlight_master_a: assert property ( // [RQ9]
    ##1 backlight_sinks_on_o == $past(mode_control_reg[LDM_MODE_BL_BIT]
                                      && mode_control_reg[LDM_MODE_RUN_BIT]))
    else $error("backlight group not following master enable");
  fault_latch_a: assert property ( // [RQ12]
    flt_rise.short_det |=> event_flags_reg[LDM_FLAG_SHORT_BIT])
    else $error("short fault not latched");
  set_wins_a: assert property ( // [RQ15]
    (|(flag_set & LDM_FLAG_MASK & flag_clr))
    |=> ((event_flags_reg & $past(flag_set)) == ($past(flag_set) & LDM_FLAG_MASK)))
    else $error("event lost to simultaneous clear");
  read_keeps_a: assert property ( // [RQ15]
    (!wr_flag && flag_set == 8'h00) |=> $stable(event_flags_reg))
    else $error("flags changed without write or event");
  masked_quiet_a: assert property ( // [RQ16]
    (irq_state_reg == LDM_IRQ_IDLE && !clear_attempt && !pend_next) |=> irq_b_o)
    else $error("interrupt driven by disabled flag");
  reserved_zero_a: assert property ( // [RQ18]
    ((event_flags_reg & ~LDM_FLAG_MASK) == 8'h00)
    && ((mode_control_reg & ~LDM_MODE_MASK) == 8'h00))
    else $error("reserved bit set");

  release_done_c: cover property (
    (irq_state_reg == LDM_IRQ_HOLD && hold_cnt_reg == '0) ##1 !irq_b_o);
  gain_force_c: cover property (gain_force_1x_o);
  override_c: cover property (indep_override && mode_control_reg[LDM_MODE_INDEP_BIT]);
  set_clear_c: cover property (|(flag_set & flag_clr & LDM_FLAG_MASK));

endmodule : ldm_mode_irq

// *** tb/ldm_host.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
module ldm_host
  import ldm_pkg::*;
(
  // Clock
  input wire logic mclk_i,
  // Access port toward the block
  input wire logic [7:0] rdata_i,
  output ldm_acc_t acc_o
);
  initial acc_o = '0;

  // One strobe cycle per access. Between accesses the address and data
  // show the inverse of the last values, so nothing leans on a stale bus.
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    acc_o = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge mclk_i);
    acc_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : put

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    put(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    put(1'b0, a, 8'h00);
    d = rdata_i;
  endtask : rd
endmodule : ldm_host

// *** tb/led_driver_mode_and_irq_status_tb.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
module led_driver_mode_and_irq_status_tb;
  import ldm_pkg::*;
  logic mclk_i, rst_b_i, leds_off, bl_fade, bl_prof;
  logic run, bl_on, ind_on, gforce, gdown, irq_b;
  logic [7:0] rdata, int_en, v;
  logic [8:0] grp, auto_en, off_sel, lit;
  ldm_acc_t acc;
  ldm_fault_t flt;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;

  ldm_mode_irq dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .acc_i(acc), .rdata_o(rdata),
    .int_enable_i(int_en), .indep_group_i(grp), .sink_auto_enable_i(auto_en),
    .indep_off_sel_i(off_sel), .sink_lit_i(lit), .all_leds_off_i(leds_off),
    .bl_fade_done_i(bl_fade), .bl_profile_done_i(bl_prof), .fault_i(flt),
    .run_o(run), .backlight_sinks_on_o(bl_on), .indep_sinks_on_o(ind_on),
    .gain_force_1x_o(gforce), .gain_down_ok_o(gdown), .irq_b_o(irq_b));
  ldm_host host (.mclk_i(mclk_i), .rdata_i(rdata), .acc_o(acc));

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  // The whole run needs about 2100 cycles; this ceiling only catches a hang.
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t ns: got 0x%h expected 0x%h", $time, got, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : wt

  // Fault inputs pass a two-stage synchroniser, so allow a few cycles.
  task automatic flags(input logic [7:0] exp);
    wt(5);
    host.rd(LDM_FLAG_ADDR, v);
    chk(v, exp);
  endtask : flags

  task automatic blmax(input logic [7:0] exp);
    logic g;
    host.wr(LDM_BLMAX_ADDR, 8'h3F);
    g = gforce;
    wt(1);
    g = g | gforce;
    chk(8'(g), exp);
  endtask : blmax

  initial begin
    rst_b_i = 1'b0;
    int_en = 8'h00;
    grp = 9'h000;
    auto_en = 9'h000;
    off_sel = 9'h001;
    lit = 9'h001;
    leds_off = 1'b0;
    bl_fade = 1'b0;
    bl_prof = 1'b0;
    flt = '0;
    wt(4);
    rst_b_i = 1'b1;
    host.rd(LDM_MODE_ADDR, v);
    chk(v, 8'h00);
    host.rd(LDM_FLAG_ADDR, v);
    chk(v, 8'h00);
    chk(8'(irq_b), 8'h01);
    chk(8'(run), 8'h00);
    $display("test reset done");

    host.wr(LDM_MODE_ADDR, 8'hFF);
    host.rd(LDM_MODE_ADDR, v);
    chk(v, 8'h7D);
    chk(8'(run), 8'h01);
    chk(8'(bl_on), 8'h01);
    chk(8'(ind_on), 8'h01);
    chk(8'(gdown), 8'h00);
    leds_off = 1'b1;
    wt(2);
    chk(8'(gdown), 8'h01);
    leds_off = 1'b0;
    blmax(8'h01);
    host.wr(LDM_MODE_ADDR, 8'h21);
    wt(2);
    chk(8'(ind_on), 8'h00);
    chk(8'(gdown), 8'h01);
    blmax(8'h00);
    grp = 9'h001;
    auto_en = 9'h001;
    host.wr(LDM_MODE_ADDR, 8'h25);
    wt(2);
    chk(8'(ind_on), 8'h00);
    auto_en = 9'h000;
    wt(2);
    chk(8'(ind_on), 8'h01);
    host.wr(LDM_MODE_ADDR, 8'h05);
    wt(2);
    chk(8'(run), 8'h00);
    chk(8'(bl_on), 8'h00);
    $display("test mode done");

    host.wr(LDM_MODE_ADDR, 8'h20);
    bl_fade = 1'b1;
    wt(1);
    bl_fade = 1'b0;
    flags(8'h20);
    host.wr(LDM_FLAG_ADDR, 8'h20);
    flags(8'h00);
    bl_prof = 1'b1;
    wt(1);
    bl_prof = 1'b0;
    flags(8'h20);
    lit = 9'h000;
    flags(8'h60);
    flt.short_det = 1'b1;
    flags(8'h70);
    flt.therm_det = 1'b1;
    flags(8'h78);
    flt.ovp_det = 1'b1;
    flags(8'h7C);
    flags(8'h7C);
    host.wr(LDM_FLAG_ADDR, 8'h83);
    flags(8'h7C);
    $display("test flags done");

    chk(8'(irq_b), 8'h01);
    int_en = 8'h1C;
    wt(2);
    chk(8'(irq_b), 8'h00);
    host.wr(LDM_FLAG_ADDR, 8'h04);
    chk(8'(irq_b), 8'h00);
    wt(3);
    chk(8'(irq_b), 8'h00);
    host.wr(LDM_MODE_ADDR, 8'h60);
    host.wr(LDM_FLAG_ADDR, 8'h08);
    chk(8'(irq_b), 8'h01);
    wt(1998);
    chk(8'(irq_b), 8'h01);
    wt(2);
    chk(8'(irq_b), 8'h00);
    host.wr(LDM_FLAG_ADDR, 8'h7C);
    flags(8'h00);
    $display("test interrupt done");
    print_verdict();
  end
endmodule : led_driver_mode_and_irq_status_tb
